/* File: pkg/ptb_consts.vh */
`ifndef PTB_CONSTS_VH
`define PTB_CONSTS_VH

// ==========================================================
// Bus widths
`define PTB_ADDR_W 4
`define PTB_DATA_W 8
`define PTB_CNT_W 16
`define PTB_FRAC_W 4

// ==========================================================
// Register offsets
`define PTB_OFF_TMRL 4'h0
`define PTB_OFF_TMRH 4'h1
`define PTB_OFF_PHL 4'h2
`define PTB_OFF_PHH 4'h3
`define PTB_OFF_DCL 4'h4
`define PTB_OFF_DCH 4'h5
`define PTB_OFF_PRL 4'h6
`define PTB_OFF_PRH 4'h7
`define PTB_OFF_DBR 4'h8
`define PTB_OFF_DBF 4'h9
`define PTB_OFF_FFA 4'hA
`define PTB_OFF_BLKR 4'hB
`define PTB_OFF_CTRL 4'hC
`define PTB_OFF_STAT 4'hD

// ==========================================================
// Reset values
`define PTB_RST_TMR 16'h0100
`define PTB_RST_CNT16 16'h0000
`define PTB_RST_BYTE 8'h00
`define PTB_RST_FRAC 4'h0
`define PTB_ZERO_BYTE 8'h00
`define PTB_ZERO_NIB 4'h0

// ==========================================================
// Field positions
`define PTB_CTRL_EN 0
`define PTB_STAT_RAW 0
`define PTB_STAT_OUTA 1
`define PTB_STAT_OUTB 2
`define PTB_STAT_EXT 3
`define PTB_STAT_BLANK 4
`define PTB_STAT_RUN 5

`endif

/* File: core/ptb_edge_delay.v */
`timescale 1ns/1ps
`include "ptb_consts.vh"

// ==========================================================
// Delays the rising edge of a level by a count of clocks
module ptb_edge_delay #(
  parameter DLY_W = `PTB_DATA_W
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire level_i,
  input wire [DLY_W-1:0] delay_i,
  output wire level_o
);

  reg prev_reg;
  reg busy_reg;
  reg [DLY_W-1:0] cnt_reg;
  reg out_reg;
  wire [DLY_W-1:0] zero_w;
  wire rise_w;

  assign zero_w = {DLY_W{1'b0}};
  assign rise_w = level_i & ~prev_reg;
  assign level_o = out_reg;

  // ==========================================================
  // Falling edge passes at once; rising edge waits out the count
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      cnt_reg <= {DLY_W{1'b0}};
      out_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
      if (!level_i) begin
        busy_reg <= 1'b0;
        out_reg <= 1'b0;
      end else if (rise_w) begin
        if (delay_i == zero_w) begin
          out_reg <= 1'b1;
          busy_reg <= 1'b0;
        end else begin
          cnt_reg <= delay_i;
          busy_reg <= 1'b1;
        end
      end else if (busy_reg) begin
        // Count already loaded; a short pulse just never shows
        if (cnt_reg == {{(DLY_W-1){1'b0}}, 1'b1}) begin
          busy_reg <= 1'b0;
          out_reg <= 1'b1;
        end
        cnt_reg <= cnt_reg - {{(DLY_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: core/ptb_top.v */
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`include "ptb_consts.vh"

module ptb_top (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [`PTB_ADDR_W-1:0] addr_i,
  input wire [`PTB_DATA_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [`PTB_DATA_W-1:0] rdata_o,
  output wire pwm_a_o,
  output wire pwm_b_o,
  output wire blank_o,
  output wire period_evt_o
);

  // ==========================================================
  // Helpers
  function [`PTB_CNT_W-1:0] merge_byte;
    input [`PTB_CNT_W-1:0] old_val;
    input [`PTB_DATA_W-1:0] byte_val;
    input hi_sel;
    begin
      if (hi_sel) begin
        merge_byte = {byte_val, old_val[`PTB_DATA_W-1:0]};
      end else begin
        merge_byte = {old_val[`PTB_CNT_W-1:`PTB_DATA_W], byte_val};
      end
    end
  endfunction

  function hit;
    input strobe;
    input [`PTB_ADDR_W-1:0] a;
    input [`PTB_ADDR_W-1:0] off;
    begin
      hit = strobe && (a == off);
    end
  endfunction

  function [`PTB_DATA_W-1:0] byte_of;
    input [`PTB_CNT_W-1:0] val;
    input hi_sel;
    begin
      if (hi_sel) begin
        byte_of = val[`PTB_CNT_W-1:`PTB_DATA_W];
      end else begin
        byte_of = val[`PTB_DATA_W-1:0];
      end
    end
  endfunction

  // ==========================================================
  // Storage
  reg [`PTB_CNT_W-1:0] tmr_reg;
  reg [`PTB_CNT_W-1:0] tmr_next;
  reg [`PTB_CNT_W-1:0] phase_reg;
  reg [`PTB_CNT_W-1:0] duty_reg;
  reg [`PTB_CNT_W-1:0] period_reg;
  reg [`PTB_DATA_W-1:0] dbr_reg;
  reg [`PTB_DATA_W-1:0] dbf_reg;
  reg [`PTB_FRAC_W-1:0] ffa_reg;
  reg [`PTB_DATA_W-1:0] blkr_reg;
  reg enable_reg;
  reg [`PTB_FRAC_W-1:0] acc_reg;
  reg [`PTB_FRAC_W-1:0] acc_next;
  reg ext_reg;
  reg ext_next;
  reg evt_reg;
  reg evt_next;
  reg raw_reg;
  reg [`PTB_DATA_W-1:0] blk_cnt_reg;
  reg blank_reg;
  reg prev_a_reg;
  reg [`PTB_DATA_W-1:0] rdata_reg;
  reg [`PTB_DATA_W-1:0] rdata_next;

  wire wr_tmrl;
  wire wr_tmrh;
  wire at_period;
  wire [`PTB_FRAC_W:0] frac_sum;
  wire raw_next;
  wire out_a;
  wire out_b;
  wire a_rise;
  wire [`PTB_CNT_W-1:0] one16;
  wire [`PTB_DATA_W-1:0] one8;

  assign one16 = 16'h0001;
  assign one8 = 8'h01;
  assign wr_tmrl = hit(wr_i, addr_i, `PTB_OFF_TMRL);
  assign wr_tmrh = hit(wr_i, addr_i, `PTB_OFF_TMRH);

  // ==========================================================
  // Configuration registers, same values on any reset
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= `PTB_RST_CNT16;
      duty_reg <= `PTB_RST_CNT16;
      period_reg <= `PTB_RST_CNT16;
      dbr_reg <= `PTB_RST_BYTE;
      dbf_reg <= `PTB_RST_BYTE;
      ffa_reg <= `PTB_RST_FRAC;
      blkr_reg <= `PTB_RST_BYTE;
      enable_reg <= 1'b0;
    end else begin
      if (hit(wr_i, addr_i, `PTB_OFF_PHL)) begin
        phase_reg <= merge_byte(phase_reg, wdata_i, 1'b0);
      end
      if (hit(wr_i, addr_i, `PTB_OFF_PHH)) begin
        phase_reg <= merge_byte(phase_reg, wdata_i, 1'b1);
      end
      if (hit(wr_i, addr_i, `PTB_OFF_DCL)) begin
        duty_reg <= merge_byte(duty_reg, wdata_i, 1'b0);
      end
      if (hit(wr_i, addr_i, `PTB_OFF_DCH)) begin
        duty_reg <= merge_byte(duty_reg, wdata_i, 1'b1);
      end
      if (hit(wr_i, addr_i, `PTB_OFF_PRL)) begin
        period_reg <= merge_byte(period_reg, wdata_i, 1'b0);
      end
      if (hit(wr_i, addr_i, `PTB_OFF_PRH)) begin
        period_reg <= merge_byte(period_reg, wdata_i, 1'b1);
      end
      if (hit(wr_i, addr_i, `PTB_OFF_DBR)) begin
        dbr_reg <= wdata_i;
      end
      if (hit(wr_i, addr_i, `PTB_OFF_DBF)) begin
        dbf_reg <= wdata_i;
      end
      if (hit(wr_i, addr_i, `PTB_OFF_FFA)) begin
        // Only the low nibble exists
        ffa_reg <= wdata_i[`PTB_FRAC_W-1:0];
      end
      if (hit(wr_i, addr_i, `PTB_OFF_BLKR)) begin
        blkr_reg <= wdata_i;
      end
      if (hit(wr_i, addr_i, `PTB_OFF_CTRL)) begin
        enable_reg <= wdata_i[`PTB_CTRL_EN];
      end
    end
  end

  // ==========================================================
  // Time base with fractional period stretch
  // Each period adds the nibble to a 1/16 clock accumulator; a carry
  // holds the counter one extra clock, so the mean period grows by
  // the nibble in sixteenths. Single edges keep whole-clock jitter.
  assign at_period = (tmr_reg == period_reg);
  assign frac_sum = {1'b0, acc_reg} + {1'b0, ffa_reg};
  // A period count of zero restarts every clock except the one held after a carry: one event per cycle

  always @* begin
    tmr_next = tmr_reg;
    acc_next = acc_reg;
    ext_next = ext_reg;
    evt_next = 1'b0;
    if (enable_reg) begin
      if (at_period) begin
        if (ext_reg) begin
          tmr_next = `PTB_RST_CNT16;
          ext_next = 1'b0;
          evt_next = 1'b1;
        end else if (frac_sum[`PTB_FRAC_W]) begin
          acc_next = frac_sum[`PTB_FRAC_W-1:0];
          ext_next = 1'b1;
        end else begin
          acc_next = frac_sum[`PTB_FRAC_W-1:0];
          tmr_next = `PTB_RST_CNT16;
          evt_next = 1'b1;
        end
      end else begin
        tmr_next = tmr_reg + one16;
      end
    end
    // Software write wins over counting in the same cycle
    if (wr_tmrl) begin
      tmr_next = merge_byte(tmr_reg, wdata_i, 1'b0);
      ext_next = 1'b0;
    end
    if (wr_tmrh) begin
      tmr_next = merge_byte(tmr_reg, wdata_i, 1'b1);
      ext_next = 1'b0;
    end
  end

  // ==========================================================
  // Time base state
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmr_reg <= `PTB_RST_TMR;
      acc_reg <= `PTB_RST_FRAC;
      ext_reg <= 1'b0;
      evt_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      acc_reg <= acc_next;
      ext_reg <= ext_next;
      evt_reg <= evt_next;
    end
  end

  // ==========================================================
  // Pulse window: on from phase match, off from duty match
  assign raw_next = enable_reg && (tmr_reg >= phase_reg) && (tmr_reg < duty_reg);

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // ==========================================================
  // Dead band on each edge of the pulse
  ptb_edge_delay #(
    .DLY_W(`PTB_DATA_W)
  ) u_rise_dly (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .level_i(raw_reg),
    .delay_i(dbr_reg),
    .level_o(out_a)
  );

  // Complement side turns on only after the falling dead band
  ptb_edge_delay #(
    .DLY_W(`PTB_DATA_W)
  ) u_fall_dly (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .level_i(enable_reg & ~raw_reg),
    .delay_i(dbf_reg),
    .level_o(out_b)
  );

  // ==========================================================
  // Rising edge blanking window
  assign a_rise = out_a & ~prev_a_reg;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_a_reg <= 1'b0;
      blk_cnt_reg <= `PTB_RST_BYTE;
      blank_reg <= 1'b0;
    end else begin
      prev_a_reg <= out_a;
      // Zero length turns blanking off altogether
      if (a_rise && (blkr_reg != `PTB_ZERO_BYTE)) begin
        blk_cnt_reg <= blkr_reg;
        blank_reg <= 1'b1;
      end else if (blank_reg) begin
        if (blk_cnt_reg == one8) begin
          blank_reg <= 1'b0;
        end
        blk_cnt_reg <= blk_cnt_reg - one8;
      end
    end
  end

  // ==========================================================
  // Read port, data valid only in the cycle after the strobe
  // Reads have no side effects on any register
  always @* begin
    rdata_next = `PTB_ZERO_BYTE;
    if (rd_i) begin
      case (addr_i)
        `PTB_OFF_TMRL: begin
          rdata_next = byte_of(tmr_reg, 1'b0);
        end
        `PTB_OFF_TMRH: begin
          rdata_next = byte_of(tmr_reg, 1'b1);
        end
        `PTB_OFF_PHL: begin
          rdata_next = byte_of(phase_reg, 1'b0);
        end
        `PTB_OFF_PHH: begin
          rdata_next = byte_of(phase_reg, 1'b1);
        end
        `PTB_OFF_DCL: begin
          rdata_next = byte_of(duty_reg, 1'b0);
        end
        `PTB_OFF_DCH: begin
          rdata_next = byte_of(duty_reg, 1'b1);
        end
        `PTB_OFF_PRL: begin
          rdata_next = byte_of(period_reg, 1'b0);
        end
        `PTB_OFF_PRH: begin
          rdata_next = byte_of(period_reg, 1'b1);
        end
        `PTB_OFF_DBR: begin
          rdata_next = dbr_reg;
        end
        `PTB_OFF_DBF: begin
          rdata_next = dbf_reg;
        end
        `PTB_OFF_FFA: begin
          rdata_next = {`PTB_ZERO_NIB, ffa_reg};
        end
        `PTB_OFF_BLKR: begin
          rdata_next = blkr_reg;
        end
        `PTB_OFF_CTRL: begin
          rdata_next = {7'h00, enable_reg};
        end
        `PTB_OFF_STAT: begin
          rdata_next[`PTB_STAT_RAW] = raw_reg;
          rdata_next[`PTB_STAT_OUTA] = out_a;
          rdata_next[`PTB_STAT_OUTB] = out_b;
          rdata_next[`PTB_STAT_EXT] = ext_reg;
          rdata_next[`PTB_STAT_BLANK] = blank_reg;
          rdata_next[`PTB_STAT_RUN] = enable_reg;
        end
        default: begin
          rdata_next = `PTB_ZERO_BYTE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data register
  // Idle cycles return zero so several slaves may share one bus
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= `PTB_ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o = rdata_reg;
  assign pwm_a_o = out_a;
  assign pwm_b_o = out_b;
  assign blank_o = blank_reg;
  assign period_evt_o = evt_reg;

endmodule

/* File: dv/ptb_chk_sva.sv */
`timescale 1ns/1ps
`include "ptb_consts.vh"
// ==========================================================
// Port checker
module ptb_chk (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [`PTB_ADDR_W-1:0] addr_i,
  input wire [`PTB_DATA_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [`PTB_DATA_W-1:0] rdata_o,
  input wire pwm_a_o,
  input wire pwm_b_o,
  input wire blank_o,
  input wire period_evt_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  chk_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  chk_unmapped_rd_zero: assert property (rd_i && addr_i >= 4'hE |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_ffa_upper_zero: assert property (rd_i && addr_i == 4'hA |=> rdata_o[7:4] == 4'h0)
    else $error("adjust upper bits not zero");
  chk_reg_readback: assert property ((wr_i && addr_i >= 4'h2 && addr_i <= 4'h9)
    ##1 (rd_i && addr_i == $past(addr_i)) |=> rdata_o == $past(wdata_i, 2))
    else $error("register readback differs");
  chk_ffa_readback: assert property ((wr_i && addr_i == 4'hA) ##1 (rd_i && addr_i == 4'hA)
    |=> rdata_o == ($past(wdata_i, 2) & 8'h0F))
    else $error("adjust readback differs");
  chk_no_overlap: assert property (!(pwm_a_o && pwm_b_o))
    else $error("both outputs high");
  chk_evt_one_cycle: assert property (period_evt_o |=> !period_evt_o)
    else $error("period event longer than one cycle");
  chk_blank_at_rise: assert property ($rose(blank_o) |->
    $past(pwm_a_o) && !$past(pwm_a_o, 2))
    else $error("blanking started without a primary output rise");

  cover property ($rose(pwm_a_o));
  cover property (period_evt_o);
  cover property ($rose(blank_o));
  cover property (rd_i && addr_i == 4'hA);
endmodule

/* File: dv/ptb_stage_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Power stage: on-time of each switch over the last period
module ptb_stage_model (
  input wire mclk_i,
  input wire reset_n_i,
  input wire pwm_a_i,
  input wire pwm_b_i,
  input wire period_evt_i,
  input wire blank_i,
  output logic [7:0] blank_high_o,
  output logic [7:0] a_high_o,
  output logic [7:0] b_high_o,
  output logic shoot_o
);
  logic [7:0] a_run;
  logic [7:0] b_run;
  logic [7:0] k_run;
  // Both switches on would short the rail, so the flag is sticky
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      a_run <= 8'h00;
      b_run <= 8'h00;
      a_high_o <= 8'h00;
      b_high_o <= 8'h00;
      k_run <= 8'h00;
      blank_high_o <= 8'h00;
      shoot_o <= 1'b0;
    end else begin
      if (pwm_a_i && pwm_b_i) shoot_o <= 1'b1;
      if (period_evt_i) begin
        a_high_o <= a_run;
        b_high_o <= b_run;
        blank_high_o <= k_run;
        a_run <= {7'h00, pwm_a_i};
        b_run <= {7'h00, pwm_b_i};
        k_run <= {7'h00, blank_i};
      end else begin
        a_run <= a_run + {7'h00, pwm_a_i};
        b_run <= b_run + {7'h00, pwm_b_i};
        k_run <= k_run + {7'h00, blank_i};
      end
    end
  end
endmodule

/* File: dv/ptb_top_tb.sv */
`timescale 1ns/1ps
`include "ptb_consts.vh"
// ==========================================================
// Bench top
module ptb_top_tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [7:0] rdata_o;
  wire pwm_a_o;
  wire pwm_b_o;
  wire blank_o;
  wire period_evt_o;
  wire [7:0] a_high;
  wire [7:0] b_high;
  wire [7:0] blank_high;
  wire shoot;
  int mismatches = 0;
  int samples_checked = 0;

  always #2.5 mclk_i = ~mclk_i;

  ptb_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o),
    .blank_o(blank_o), .period_evt_o(period_evt_o));
  ptb_stage_model STG (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pwm_a_i(pwm_a_o),
    .pwm_b_i(pwm_b_o), .period_evt_i(period_evt_o), .blank_i(blank_o),
    .blank_high_o(blank_high), .a_high_o(a_high), .b_high_o(b_high), .shoot_o(shoot));

  // ==========================================================
  // Checking and bus tasks
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [3:0] a, input logic [7:0] dd);
    return (a == `PTB_OFF_FFA) ? (dd & 8'h0F) : dd;
  endfunction

  function automatic logic [7:0] cfg_val(input int a, input logic [7:0] db, input logic [7:0] ff);
    case (a)
      2, 12: return 8'h01;
      4, 6: return 8'h03;
      8, 9: return db;
      10: return ff;
      11: return 8'h02;
      default: return 8'h00;
    endcase
  endfunction

  // Writes leave a gap edge so the strobe is never driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] dd);
    addr_i <= a;
    wdata_i <= dd;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] dd);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    dd = rdata_o;
    @(posedge mclk_i);
  endtask

  // Write followed at once by a read of the same place
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] dd, output logic [7:0] v);
    addr_i <= a;
    wdata_i <= dd;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd(a, v);
  endtask

  task automatic reset_table;
    logic [7:0] v;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v);
      chk(v, (a == 1) ? 8'h01 : 8'h00);
    end
  endtask

  task automatic cfg(input logic [7:0] db, input logic [7:0] ff);
    for (int a = 0; a < 13; a++) wr(4'(a), cfg_val(a, db, ff));
  endtask

  task automatic wait_evt(output int n);
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (period_evt_o !== 1'b1 && n < 200);
    if (n >= 200) begin
      mismatches++;
      $display("Error at %0t: period event timeout", $time);
      final_report();
    end
    @(posedge mclk_i);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] v;
    int n;
    int tot;
    void'($urandom(32'hda8f_7745));
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    reset_table();
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? `PTB_OFF_FFA : 4'h2 + 4'($urandom_range(9));
      d = (i == 0) ? 8'hFF : 8'($urandom);
      wr_rd(a, d, v);
      chk(v, exp_rd(a, d));
    end
    wr(4'hE, 8'h5A);
    rd(4'hE, v);
    chk(v, 8'h00);
    for (int k = 0; k < 4; k++) begin
      cfg(8'(k), 8'h00);
      repeat (3) wait_evt(n);
      wait_evt(n);
      chk(8'(n), 8'h04);
      @(negedge mclk_i);
      chk(a_high, 8'((k < 2) ? 2 - k : 0));
      chk(b_high, 8'((k < 2) ? 2 - k : 0));
      chk(blank_high, 8'((k < 2) ? 2 : 0));
      @(posedge mclk_i);
    end
    cfg(8'h00, 8'h05);
    repeat (3) wait_evt(n);
    tot = 0;
    repeat (16) begin
      wait_evt(n);
      tot += n;
    end
    chk(8'(tot), 8'h45);
    wr(`PTB_OFF_CTRL, 8'h00);
    rd(`PTB_OFF_TMRL, d);
    rd(`PTB_OFF_TMRL, v);
    chk(v, d);
    rd(`PTB_OFF_TMRH, v);
    chk(v, 8'h00);
    chk({7'h00, shoot}, 8'h00);
    wr(`PTB_OFF_CTRL, 8'h01);
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({4'h0, pwm_a_o, pwm_b_o, blank_o, period_evt_o}, 8'h00);
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    reset_table();
    final_report();
  end
endmodule

bind ptb_top ptb_chk CHK (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_a_o(pwm_a_o),
  .pwm_b_o(pwm_b_o), .blank_o(blank_o), .period_evt_o(period_evt_o));
